// file: mixed_signal_interrupt_flags_tb_top.sv
// testbench for the event flag block: events in, register reads out.
// assumes the host model drives the read port; other inputs are driven here.
`default_nettype none

module mixed_signal_interrupt_flags_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import mxf_pkg::*;

	// ----------------------------------------------------------
	// signals
	// ----------------------------------------------------------
	logic           mclk, rst, conv_done, sweep_done, supply_low_det, rd_en, rd_valid_r;
	mxf_conv_mode_t conv_mode;
	logic [19:0]    port_result, data_read, data_load_r, gpi_pin, ovc_det;
	logic [59:0]    avg_log2;
	logic [39:0]    gpi_mode;
	logic [2:0]     temp_valid;
	logic [35:0]    temp_data, temp_upper, temp_lower;
	logic [7:0]     rd_addr;
	logic [15:0]    rd_data_r;
	int             fails, check_count;

	mxf_event_flags DUT (.mclk(mclk), .rst(rst), .conv_mode(conv_mode),
		.conv_done(conv_done), .sweep_done(sweep_done), .port_result(port_result),
		.avg_log2(avg_log2), .data_read(data_read), .data_load_r(data_load_r),
		.gpi_pin(gpi_pin), .gpi_mode(gpi_mode), .ovc_det(ovc_det),
		.supply_low_det(supply_low_det), .temp_valid(temp_valid), .temp_data(temp_data),
		.temp_upper(temp_upper), .temp_lower(temp_lower), .rd_en(rd_en),
		.rd_addr(rd_addr), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r));

	mxf_host_model host (.mclk(mclk), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r),
		.rd_en(rd_en), .rd_addr(rd_addr));

	// ----------------------------------------------------------
	// tasks
	// ----------------------------------------------------------
	task automatic check(input logic [19:0] seen, input logic [19:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		logic [15:0] d;
		logic        v;
		host.read_reg(a, d, v);
		check({19'h0_0000, v}, 20'h0_0001);
		check({4'h0, d}, {4'h0, exp});
	endtask : rd

	// one commit strobe; the load pulse is looked at in the cycle it stands
	task automatic commit(input logic cd, input logic sd, input logic [19:0] p,
		input logic [19:0] exp);
		@(negedge mclk);
		port_result = p;
		conv_done   = cd;
		sweep_done  = sd;
		@(negedge mclk);
		conv_done   = 1'b0;
		sweep_done  = 1'b0;
		port_result = 20'h0_0000;
		check(data_load_r, exp);
	endtask : commit

	task automatic temp(input int c, input logic [11:0] t, input logic [15:0] exp);
		temp_data[12*c +: 12] = t;
		temp_valid = 3'(1 << c);
		@(negedge mclk);
		temp_valid = 3'h0;
		rd(REG_EVENT_FLAGS, exp);
	endtask : temp

	task automatic idle(input int n);
		repeat (n) @(negedge mclk);
	endtask : idle

	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : finish_test

	// ----------------------------------------------------------
	// clock and watchdog
	// ----------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	// whole run is well under a thousand cycles
	initial begin
		repeat (5000) @(posedge mclk);
		fails++;
		finish_test();
	end

	// ----------------------------------------------------------
	// tests
	// ----------------------------------------------------------
	initial begin
		rst = 1'b1;
		conv_mode = CONV_IDLE;
		{conv_done, sweep_done, supply_low_det} = 3'h0;
		{port_result, data_read, gpi_pin, ovc_det} = 80'h0;
		avg_log2 = 60'h000_0000_0000_8000; // port 5 averages two samples
		gpi_mode = 40'hc0_0000_0240; // port 3 rising, 4 falling, 19 both
		temp_valid = 3'h0;
		temp_data = 36'h0_0000_0000;
		temp_upper = 36'h0_6406_4064; // +100 on every channel
		temp_lower = 36'hf_9cf9_cf9c; // -100 on every channel
		fails = 0;
		check_count = 0;
		repeat (4) @(negedge mclk);
		rst = 1'b0;
		idle(4);
		rd(REG_PART_ID, PART_ID_DEF);
		rd(REG_EVENT_FLAGS, 16'h0000);
		rd(8'h0a, 16'h0000);
		$display("test ident done");
		commit(1'b1, 1'b1, 20'h0_0002, 20'h0_0000);
		rd(REG_EVENT_FLAGS, 16'h0000);
		conv_mode = CONV_SINGLE;
		commit(1'b1, 1'b0, 20'h0_0002, 20'h0_0002);
		rd(REG_EVENT_FLAGS, 16'h0003);
		rd(REG_EVENT_FLAGS, 16'h0002);
		rd(REG_SAMPLE_HI, 16'h0000);
		rd(REG_SAMPLE_LO, 16'h0002);
		rd(REG_EVENT_FLAGS, 16'h0000);
		conv_mode = CONV_SWEEP_CONT;
		commit(1'b0, 1'b1, 20'h2_0021, 20'h2_0001);
		data_read = 20'h2_0001;
		@(negedge mclk);
		data_read = 20'h0_0000;
		commit(1'b0, 1'b1, 20'h2_0021, 20'h2_0021);
		rd(REG_EVENT_FLAGS, 16'h0003);
		commit(1'b0, 1'b1, 20'h2_0021, 20'h2_0001);
		rd(REG_EVENT_FLAGS, 16'h0007);
		rd(REG_SAMPLE_LO, 16'h0021);
		rd(REG_SAMPLE_HI, 16'h0002);
		rd(REG_EVENT_FLAGS, 16'h0000);
		// single sweep: a conversion end alone must not load, the sweep end does
		conv_mode = CONV_SWEEP_ONCE;
		commit(1'b1, 1'b0, 20'h0_0004, 20'h0_0000);
		commit(1'b0, 1'b1, 20'h0_0000, 20'h0_0004);
		rd(REG_EVENT_FLAGS, 16'h0003);
		rd(REG_SAMPLE_LO, 16'h0004);
		rd(REG_SAMPLE_HI, 16'h0000);
		rd(REG_EVENT_FLAGS, 16'h0000);
		$display("test converter done");
		gpi_pin = 20'h8_0018;
		idle(6);
		rd(REG_EVENT_FLAGS, 16'h0008);
		gpi_pin = 20'h0_0000;
		idle(6);
		gpi_pin = 20'h8_0018;
		idle(6);
		rd(REG_EVENT_FLAGS, 16'h0018);
		rd(REG_INPUT_LO, 16'h0018);
		rd(REG_INPUT_HI, 16'h0008);
		rd(REG_EVENT_FLAGS, 16'h0000);
		$display("test inputs done");
		ovc_det = 20'h4_0000;
		idle(6);
		rd(REG_EVENT_FLAGS, 16'h0020);
		rd(REG_OVC_LO, 16'h0000);
		rd(REG_EVENT_FLAGS, 16'h0020);
		rd(REG_OVC_LO, 16'h0000);
		rd(REG_OVC_HI, 16'h0004);
		rd(REG_EVENT_FLAGS, 16'h0000);
		// the first read lands on the very edge that sees the supply event
		supply_low_det = 1'b1;
		idle(1);
		rd(REG_EVENT_FLAGS, 16'h0000);
		rd(REG_EVENT_FLAGS, 16'h8000);
		rd(REG_EVENT_FLAGS, 16'h0000);
		$display("test monitors done");
		// above, below and exactly at the upper limit on each channel
		for (int c = 0; c < 3; c++) begin
			temp(c, 12'h0c8, 16'h0005 << (6 + 3 * c));
			temp(c, 12'hf38, 16'h0003 << (6 + 3 * c));
			temp(c, 12'h064, 16'h0001 << (6 + 3 * c));
		end
		$display("test temperature done");
		finish_test();
	end
endmodule : mixed_signal_interrupt_flags_tb_top

`default_nettype wire

// file: mxf_event_flags.sv
// constants and the event flag block of the mixed-signal port device.
// assumes converter, temperature and data-register logic share mclk;
// the comparator and input pins arrive asynchronously.
`default_nettype none

package mxf_pkg;
	// --------------------------------------------------------------
	// sizes
	// --------------------------------------------------------------
	localparam int unsigned PORT_COUNT = 20;
	localparam int unsigned REG_W      = 16;
	localparam int unsigned ADDR_W     = 8;
	localparam int unsigned AVG_W      = 3;
	localparam int unsigned AVG_CNT_W  = 7;
	localparam int unsigned TEMP_W     = 12;
	localparam int unsigned TEMP_CH    = 3;
	localparam int unsigned ST_LO_W    = 16;

	// register indices
	localparam logic [ADDR_W-1:0] REG_PART_ID    = 8'h00;
	localparam logic [ADDR_W-1:0] REG_EVENT_FLAGS = 8'h01;
	localparam logic [ADDR_W-1:0] REG_SAMPLE_LO  = 8'h02;
	localparam logic [ADDR_W-1:0] REG_SAMPLE_HI  = 8'h03;
	localparam logic [ADDR_W-1:0] REG_INPUT_LO   = 8'h04;
	localparam logic [ADDR_W-1:0] REG_INPUT_HI   = 8'h05;
	localparam logic [ADDR_W-1:0] REG_OVC_LO     = 8'h06;
	localparam logic [ADDR_W-1:0] REG_OVC_HI     = 8'h07;

	// event flag bit positions
	localparam int unsigned BIT_CONV_DONE     = 0;
	localparam int unsigned BIT_SAMPLE_READY  = 1;
	localparam int unsigned BIT_SAMPLE_MISSED = 2;
	localparam int unsigned BIT_INPUT_EVENT   = 3;
	localparam int unsigned BIT_INPUT_MISSED  = 4;
	localparam int unsigned BIT_OVERCURRENT   = 5;
	localparam int unsigned BIT_TEMP_BASE     = 6;
	localparam int unsigned BIT_SUPPLY_LOW    = 15;
	// offsets inside one temperature triple
	localparam int unsigned TEMP_NEW  = 0;
	localparam int unsigned TEMP_LOW  = 1;
	localparam int unsigned TEMP_HIGH = 2;

	// reset values and read-clear bits (0, 2, 6..15)
	localparam logic [REG_W-1:0] EVENT_FLAGS_RST = 16'h0000;
	localparam logic [REG_W-1:0] READ_CLEAR_MASK = 16'hffc5;
	// arbitrary identifier value, not tied to any real part
	localparam logic [REG_W-1:0] PART_ID_DEF     = 16'h5a3c;

	// input event selection per port
	localparam logic [1:0] GPI_OFF  = 2'h0;
	localparam logic [1:0] GPI_RISE = 2'h1;
	localparam logic [1:0] GPI_FALL = 2'h2;
	localparam logic [1:0] GPI_BOTH = 2'h3;

	typedef enum logic [1:0] {
		CONV_IDLE,
		CONV_SINGLE,
		CONV_SWEEP_ONCE,
		CONV_SWEEP_CONT
	} mxf_conv_mode_t;
endpackage : mxf_pkg

module mxf_event_flags #(
	parameter int unsigned              NUM_PORTS = mxf_pkg::PORT_COUNT,
	parameter logic [mxf_pkg::REG_W-1:0] PART_ID  = mxf_pkg::PART_ID_DEF
) (
	// clock and reset
	input  wire logic                                      mclk,
	input  wire logic                                      rst,
	// converter engine
	input  wire mxf_pkg::mxf_conv_mode_t                   conv_mode,
	input  wire logic                                      conv_done,
	input  wire logic                                      sweep_done,
	input  wire logic [NUM_PORTS-1:0]                      port_result,
	input  wire logic [NUM_PORTS*mxf_pkg::AVG_W-1:0]       avg_log2,
	input  wire logic [NUM_PORTS-1:0]                      data_read,
	output logic      [NUM_PORTS-1:0]                      data_load_r,
	// general-purpose inputs and driver monitors (asynchronous)
	input  wire logic [NUM_PORTS-1:0]                      gpi_pin,
	input  wire logic [NUM_PORTS*2-1:0]                    gpi_mode,
	input  wire logic [NUM_PORTS-1:0]                      ovc_det,
	input  wire logic                                      supply_low_det,
	// temperature channels: internal, remote one, remote two
	input  wire logic [mxf_pkg::TEMP_CH-1:0]               temp_valid,
	input  wire logic [mxf_pkg::TEMP_CH*mxf_pkg::TEMP_W-1:0] temp_data,
	input  wire logic [mxf_pkg::TEMP_CH*mxf_pkg::TEMP_W-1:0] temp_upper,
	input  wire logic [mxf_pkg::TEMP_CH*mxf_pkg::TEMP_W-1:0] temp_lower,
	// host register reads
	input  wire logic                                      rd_en,
	input  wire logic [mxf_pkg::ADDR_W-1:0]                rd_addr,
	output logic      [mxf_pkg::REG_W-1:0]                 rd_data_r,
	output logic                                           rd_valid_r
);
	import mxf_pkg::*;

	localparam int unsigned PIN_W = 2*NUM_PORTS + 1;

	// --------------------------------------------------------------
	// pin synchronisers
	// --------------------------------------------------------------
	logic [PIN_W-1:0] pin_s1_r;
	logic [PIN_W-1:0] pin_s2_r;
	logic [PIN_W-1:0] pin_d_r;
	logic [PIN_W-1:0] pin_rise;
	logic [PIN_W-1:0] pin_fall;

	// only pin_s2_r reads pin_s1_r; edges are taken after the second stage
	always_ff @(posedge mclk) begin
		if (rst) begin
			pin_s1_r <= '0;
			pin_s2_r <= '0;
			pin_d_r  <= '0;
		end else begin
			pin_s1_r <= {supply_low_det, ovc_det, gpi_pin};
			pin_s2_r <= pin_s1_r;
			pin_d_r  <= pin_s2_r;
		end
	end
	assign pin_rise = pin_s2_r & ~pin_d_r;
	assign pin_fall = ~pin_s2_r & pin_d_r;

	// --------------------------------------------------------------
	// converter completion and data loads
	// --------------------------------------------------------------
	logic                 commit;
	logic [NUM_PORTS-1:0] res_pend_r;
	logic [NUM_PORTS-1:0] sample_in;
	logic [NUM_PORTS-1:0] load_now;
	logic [NUM_PORTS-1:0] unread_r;
	logic                 missed_ev;
	logic [AVG_CNT_W-1:0] avg_cnt_r [NUM_PORTS];
	logic [AVG_CNT_W-1:0] avg_mask  [NUM_PORTS];

	// idle mode never commits, so no done flag and no load can occur there
	assign commit = ((conv_mode == CONV_SINGLE) & conv_done)
		| (((conv_mode == CONV_SWEEP_ONCE) | (conv_mode == CONV_SWEEP_CONT)) & sweep_done);

	// results wait for the end of their conversion or sweep before loading
	assign sample_in = commit ? (res_pend_r | port_result) : '0;
	always_ff @(posedge mclk) begin
		if (rst)
			res_pend_r <= '0;
		else
			res_pend_r <= commit ? '0 : (res_pend_r | port_result);
	end

	// per-port averaging: the data register loads on the 2^N-th sample
	for (genvar i = 0; i < NUM_PORTS; i++) begin : g_avg
		assign avg_mask[i] = AVG_CNT_W'((8'h01 << avg_log2[i*AVG_W +: AVG_W]) - 8'h01);
		assign load_now[i] = sample_in[i] & (avg_cnt_r[i] == avg_mask[i]);
		always_ff @(posedge mclk) begin
			if (rst)
				avg_cnt_r[i] <= '0;
			else if (load_now[i])
				avg_cnt_r[i] <= '0;
			else if (sample_in[i])
				avg_cnt_r[i] <= avg_cnt_r[i] + AVG_CNT_W'(1);
		end
		AST_AVG_SKIP: assert property (@(posedge mclk) disable iff (rst)
			(sample_in[i] && avg_cnt_r[i] != avg_mask[i]) |=> !data_load_r[i])
			else $error("averaging port loaded early");
	end

	// a load over a value the host has not read yet is a miss
	assign missed_ev = |(load_now & unread_r & ~data_read);
	always_ff @(posedge mclk) begin
		if (rst) begin
			unread_r    <= '0;
			data_load_r <= '0;
		end else begin
			unread_r    <= load_now | (unread_r & ~data_read);
			data_load_r <= load_now;
		end
	end

	// --------------------------------------------------------------
	// input events, overcurrent, temperature, supply
	// --------------------------------------------------------------
	logic [NUM_PORTS-1:0]   gpi_hit;
	logic [NUM_PORTS-1:0]   ovc_rise;
	logic [TEMP_CH*3-1:0]   temp_ev;
	logic                   supply_ev;

	for (genvar i = 0; i < NUM_PORTS; i++) begin : g_gpi
		assign gpi_hit[i] = (gpi_mode[2*i +: 2] == GPI_RISE) & pin_rise[i]
			| (gpi_mode[2*i +: 2] == GPI_FALL) & pin_fall[i]
			| (gpi_mode[2*i +: 2] == GPI_BOTH) & (pin_rise[i] | pin_fall[i]);
	end
	assign ovc_rise  = pin_rise[2*NUM_PORTS-1:NUM_PORTS];
	// entering the low-supply state raises the flag once per dip
	assign supply_ev = pin_rise[PIN_W-1];

	// signed compare of each reading against its own limits
	for (genvar c = 0; c < TEMP_CH; c++) begin : g_temp
		assign temp_ev[3*c+TEMP_NEW]  = temp_valid[c];
		assign temp_ev[3*c+TEMP_LOW]  = temp_valid[c]
			& ($signed(temp_data[c*TEMP_W +: TEMP_W]) < $signed(temp_lower[c*TEMP_W +: TEMP_W]));
		assign temp_ev[3*c+TEMP_HIGH] = temp_valid[c]
			& ($signed(temp_data[c*TEMP_W +: TEMP_W]) > $signed(temp_upper[c*TEMP_W +: TEMP_W]));
	end

	// --------------------------------------------------------------
	// register reads and status groups
	// --------------------------------------------------------------
	logic                 int_rd;
	logic [NUM_PORTS-1:0] sample_st;
	logic [NUM_PORTS-1:0] input_st;
	logic [NUM_PORTS-1:0] ovc_st;
	logic                 sample_flag;
	logic                 input_flag;
	logic                 ovc_flag;
	logic                 input_clr;
	logic                 input_missed_r;
	logic                 input_missed_ev;

	assign int_rd = rd_en & (rd_addr == REG_EVENT_FLAGS);

	mxf_status_group #(.WIDTH(NUM_PORTS)) u_sample_grp (
		.mclk     (mclk),
		.rst      (rst),
		.set_vec  (load_now),
		.int_rd   (int_rd),
		.lo_rd    (rd_en & (rd_addr == REG_SAMPLE_LO)),
		.hi_rd    (rd_en & (rd_addr == REG_SAMPLE_HI)),
		.status_r (sample_st),
		.flag_r   (sample_flag),
		.clr      ()
	);

	mxf_status_group #(.WIDTH(NUM_PORTS)) u_input_grp (
		.mclk     (mclk),
		.rst      (rst),
		.set_vec  (gpi_hit),
		.int_rd   (int_rd),
		.lo_rd    (rd_en & (rd_addr == REG_INPUT_LO)),
		.hi_rd    (rd_en & (rd_addr == REG_INPUT_HI)),
		.status_r (input_st),
		.flag_r   (input_flag),
		.clr      (input_clr)
	);

	mxf_status_group #(.WIDTH(NUM_PORTS)) u_ovc_grp (
		.mclk     (mclk),
		.rst      (rst),
		.set_vec  (ovc_rise),
		.int_rd   (int_rd),
		.lo_rd    (rd_en & (rd_addr == REG_OVC_LO)),
		.hi_rd    (rd_en & (rd_addr == REG_OVC_HI)),
		.status_r (ovc_st),
		.flag_r   (ovc_flag),
		.clr      ()
	);

	// a new event on a port whose status is still pending is an input miss, held until the group clears
	assign input_missed_ev = |(gpi_hit & input_st);
	always_ff @(posedge mclk) begin
		if (rst)
			input_missed_r <= 1'b0;
		else
			input_missed_r <= input_missed_ev | (input_missed_r & ~input_clr);
	end

	// --------------------------------------------------------------
	// read-clear flags
	// --------------------------------------------------------------
	logic [REG_W-1:0] rc_r;
	logic [REG_W-1:0] rc_set;
	logic [REG_W-1:0] rc_nxt;
	logic [REG_W-1:0] event_flags;

	assign rc_set = {supply_ev, temp_ev, 3'b000, missed_ev, 1'b0, commit};
	// the set term is or-ed last, so a same-cycle event survives the read
	assign rc_nxt = rc_set | (rc_r & ~(int_rd ? READ_CLEAR_MASK : 16'h0000));
	always_ff @(posedge mclk) begin
		if (rst)
			rc_r <= EVENT_FLAGS_RST;
		else
			rc_r <= rc_nxt;
	end

	assign event_flags = (rc_r & READ_CLEAR_MASK)
		| (REG_W'(sample_flag) << BIT_SAMPLE_READY)
		| (REG_W'(input_flag) << BIT_INPUT_EVENT)
		| (REG_W'(input_missed_r) << BIT_INPUT_MISSED)
		| (REG_W'(ovc_flag) << BIT_OVERCURRENT);

	// read mux: unmapped indices return zero
	logic [REG_W-1:0] rd_mux;
	assign rd_mux =
		(rd_addr == REG_PART_ID)     ? PART_ID :
		(rd_addr == REG_EVENT_FLAGS) ? event_flags :
		(rd_addr == REG_SAMPLE_LO)   ? REG_W'(sample_st) :
		(rd_addr == REG_SAMPLE_HI)   ? REG_W'(sample_st >> ST_LO_W) :
		(rd_addr == REG_INPUT_LO)    ? REG_W'(input_st) :
		(rd_addr == REG_INPUT_HI)    ? REG_W'(input_st >> ST_LO_W) :
		(rd_addr == REG_OVC_LO)      ? REG_W'(ovc_st) :
		(rd_addr == REG_OVC_HI)      ? REG_W'(ovc_st >> ST_LO_W) : 16'h0000;

	always_ff @(posedge mclk) begin
		if (rst) begin
			rd_data_r  <= 16'h0000;
			rd_valid_r <= 1'b0;
		end else begin
			rd_data_r  <= rd_en ? rd_mux : 16'h0000;
			rd_valid_r <= rd_en;
		end
	end

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	AST_DONE_SET: assert property (@(posedge mclk) disable iff (rst)
		commit |=> event_flags[BIT_CONV_DONE])
		else $error("conversion done flag not set");

	AST_DONE_IDLE: assert property (@(posedge mclk) disable iff (rst)
		(conv_mode == CONV_IDLE && !rc_r[BIT_CONV_DONE]) |=> !rc_r[BIT_CONV_DONE])
		else $error("conversion done flag rose in idle");

	AST_LOAD_FLAG: assert property (@(posedge mclk) disable iff (rst)
		(|load_now) |=> (sample_flag && data_load_r == $past(load_now)))
		else $error("data load did not raise sample ready");

	AST_MISSED: assert property (@(posedge mclk) disable iff (rst)
		missed_ev |=> event_flags[BIT_SAMPLE_MISSED])
		else $error("sample missed flag not set");

	AST_OVC: assert property (@(posedge mclk) disable iff (rst)
		(|ovc_rise) |=> event_flags[BIT_OVERCURRENT])
		else $error("overcurrent flag not set");

	AST_TEMP_NEW: assert property (@(posedge mclk) disable iff (rst)
		temp_valid[0] |=> event_flags[BIT_TEMP_BASE + TEMP_NEW])
		else $error("internal temperature new flag not set");

	AST_READ_CLEAR: assert property (@(posedge mclk) disable iff (rst)
		(int_rd && rc_set == 16'h0000) |=> (rc_r & READ_CLEAR_MASK) == 16'h0000)
		else $error("flag read did not clear read-clear bits");

	AST_ID_READ: assert property (@(posedge mclk) disable iff (rst)
		(rd_en && rd_addr == REG_PART_ID) |=> (rd_valid_r && rd_data_r == PART_ID))
		else $error("identifier read wrong");

	AST_SET_WINS: assert property (@(posedge mclk) disable iff (rst)
		(int_rd && supply_ev) |=> ##1 $past(event_flags[BIT_SUPPLY_LOW]))
		else $error("supply event lost to a same-cycle read");

endmodule : mxf_event_flags

`default_nettype wire

// file: mxf_host_model.sv
// host model: issues single register reads on the device read port.
// assumes reads are taken on rising mclk and answered one cycle later.
`default_nettype none

module mxf_host_model (
	// clock
	input  wire logic                           mclk,
	// device answer
	input  wire logic [mxf_pkg::REG_W-1:0]      rd_data_r,
	input  wire logic                           rd_valid_r,
	// request
	output var  logic                           rd_en,
	output var  logic [mxf_pkg::ADDR_W-1:0]     rd_addr
);
	timeunit 1ns;
	timeprecision 1ps;
	import mxf_pkg::*;

	// ----------------------------------------------------------
	// read cycle
	// ----------------------------------------------------------
	initial begin
		rd_en   = 1'b0;
		rd_addr = 8'h00;
	end

	// request held over one rising edge; answer taken before release
	task automatic read_reg(input logic [ADDR_W-1:0] a, output logic [REG_W-1:0] d,
		output logic v);
		@(negedge mclk);
		rd_en   = 1'b1;
		rd_addr = a;
		@(negedge mclk);
		d       = rd_data_r;
		v       = rd_valid_r;
		rd_en   = 1'b0;
		rd_addr = ~a; // idle address never repeats the last one
	endtask : read_reg
endmodule : mxf_host_model

`default_nettype wire

// file: mxf_status_group.sv
// per-port status group: a sticky status vector with its summary flag.
// assumes the host read strobes are single-cycle pulses on mclk, one register per cycle.
`default_nettype none

module mxf_status_group #(
	parameter int unsigned WIDTH = 20
) (
	// clock and reset
	input  wire logic             mclk,
	input  wire logic             rst,
	// per-port events
	input  wire logic [WIDTH-1:0] set_vec,
	// host read strobes
	input  wire logic             int_rd,
	input  wire logic             lo_rd,
	input  wire logic             hi_rd,
	// state seen by the host
	output logic      [WIDTH-1:0] status_r,
	output logic                  flag_r,
	output logic                  clr
);
	import mxf_pkg::*;

	logic             armed_r;
	logic             armed_nxt;
	logic             lo_seen_r;
	logic             lo_seen_nxt;
	logic             hi_seen_r;
	logic             hi_seen_nxt;
	logic [WIDTH-1:0] status_nxt;
	logic             flag_nxt;

	// --------------------------------------------------------------
	// clearing sequence
	// --------------------------------------------------------------
	// a flag read arms the group; both halves must then be read.
	// a fresh flag read restarts the sequence, so stale half reads never count.
	assign clr         = armed_r & (lo_seen_r | lo_rd) & (hi_seen_r | hi_rd);
	assign armed_nxt   = int_rd | (armed_r & ~clr);
	assign lo_seen_nxt = ~int_rd & ~clr & (lo_seen_r | (armed_r & lo_rd));
	assign hi_seen_nxt = ~int_rd & ~clr & (hi_seen_r | (armed_r & hi_rd));

	// new events win over a clear in the same cycle; no mask touches status
	assign status_nxt  = set_vec | (status_r & ~{WIDTH{clr}});
	assign flag_nxt    = (|set_vec) | (flag_r & ~clr);

	// state registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			armed_r   <= 1'b0;
			lo_seen_r <= 1'b0;
			hi_seen_r <= 1'b0;
			status_r  <= '0;
			flag_r    <= 1'b0;
		end else begin
			armed_r   <= armed_nxt;
			lo_seen_r <= lo_seen_nxt;
			hi_seen_r <= hi_seen_nxt;
			status_r  <= status_nxt;
			flag_r    <= flag_nxt;
		end
	end

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	AST_GRP_CLEAR: assert property (@(posedge mclk) disable iff (rst)
		(clr && !(|set_vec)) |=> (!flag_r && status_r == '0))
		else $error("status group did not clear after both halves read");

	AST_GRP_HOLD: assert property (@(posedge mclk) disable iff (rst)
		(flag_r && !armed_r && !int_rd) |=> flag_r)
		else $error("flag dropped without a flag read first");

	AST_GRP_STATUS: assert property (@(posedge mclk) disable iff (rst)
		set_vec[0] |=> (status_r[0] && flag_r))
		else $error("port event not recorded in status");

endmodule : mxf_status_group

`default_nettype wire
